// *** inc/iox_pkg.sv ***
// Overview of operation
// - After reset every port pin is an input, so nothing is driven until direction bits change.
// - The master writes one direction bit per pin and each bit steers its own pin.
// - Sampled input levels sit in an eight-bit input register and output values in an output one.
// - A set polarity bit makes the input register report the complement of that pin.
// - Power-on reset restores every register default and sends the bus machine to idle.
// - The active-low reset pin does the same initialisation as power-on reset.
// - The interrupt asserts while any input differs from its last captured input register value.
// - The interrupt pin is open drain: driven low while asserted, released otherwise.
// - One address-select pin picks one of two slave addresses.
// - The slave works with serial clocks up to fast mode; the master stays at or below it.
// - Short glitches on the serial clock and data lines are filtered before the bus machine.
// - The seven-bit address has six fixed upper bits and the select pin level as its low bit.
// - The last bit of the address byte is the direction, one for read and zero for write.
// - After an acknowledged write address the next byte goes into a write-only pointer.
`default_nettype none
package iox_pkg;
   // ----------------------------------------
   // Register pointer codes and reset values
   // ----------------------------------------
   localparam logic [1:0] PTR_INPUT = 2'h0;
   localparam logic [1:0] PTR_OUTPUT = 2'h1;
   localparam logic [1:0] PTR_POLARITY = 2'h2;
   localparam logic [1:0] PTR_CONFIG = 2'h3;
   localparam logic [7:0] RST_OUTPUT = 8'hff;
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam logic [7:0] RST_CONFIG = 8'hff;
   localparam logic [5:0] ADDR_UPPER = 6'h10;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int SCL_MAX_HZ = 400000;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000 < 1 ? 1 :
                               (GLITCH_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int FILT_LEN = GLITCH_CYC + 1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK, ST_WBYTE, ST_RBYTE, ST_RACK, ST_SKIP
   } iox_state_type;
endpackage
`default_nettype wire

// *** rtl/iox_core.sv ***
`default_nettype none
module iox_core #(
   parameter int FILT = iox_pkg::FILT_LEN
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_sel,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe,
   output logic int_n_out,
   output logic int_n_oe,
   output logic [7:0] int_out_reg,
   output logic [7:0] int_cfg_reg
);
   import iox_pkg::*;

   // Elaboration guard. The filter keeps FILT-1 history bits beside the newest sample,
   // so it needs at least two; a very long window would start to swallow real
   // fast-mode clock phases, so the upper bound is kept below half a fast-mode bit.
   initial begin
      if (FILT < 2 || FILT > 16) $error("FILT out of range");
   end

   // ----------------------------------------
   // Synchronisers and glitch filters
   // ----------------------------------------
   // Pin inputs pass two flops; the bus lines then need FILT stable samples to change,
   // which rejects spikes shorter than the filter window at the cost of a little delay.
   logic [1:0] s1, s2, next_s1, next_s2;
   logic [7:0] p1, p2, next_p1, next_p2;
   // The address-select pin is static in normal use, but it is still a pin, so it is
   // synchronised like the port pins; a change in mid-frame is first used at the next address match.
   logic a1, a2, next_a1, next_a2;
   logic [FILT-1:0] scl_h, sda_h, next_scl_h, next_sda_h;
   logic scl_f, sda_f, scl_q, sda_q, next_scl_f, next_sda_f, next_scl_q, next_sda_q;

   always_comb begin
      next_s1 = {scl_in, sda_in};
      next_s2 = s1;
      next_p1 = port_in;
      next_p2 = p1;
      next_a1 = addr_sel;
      next_a2 = a1;
      next_scl_h = {scl_h[FILT-2:0], s2[1]};
      next_sda_h = {sda_h[FILT-2:0], s2[0]};
      next_scl_f = scl_f;
      next_sda_f = sda_f;
      if (&scl_h) next_scl_f = 1'b1;
      if (~|scl_h) next_scl_f = 1'b0;
      if (&sda_h) next_sda_f = 1'b1;
      if (~|sda_h) next_sda_f = 1'b0;
      next_scl_q = scl_f;
      next_sda_q = sda_f;
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= 2'h3;
         s2 <= 2'h3;
         p1 <= 8'h00;
         p2 <= 8'h00;
         a1 <= 1'b0;
         a2 <= 1'b0;
         scl_h <= '1;
         sda_h <= '1;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (clk_en) begin
         s1 <= next_s1;
         s2 <= next_s2;
         p1 <= next_p1;
         p2 <= next_p2;
         a1 <= next_a1;
         a2 <= next_a2;
         scl_h <= next_scl_h;
         sda_h <= next_sda_h;
         scl_f <= next_scl_f;
         sda_f <= next_sda_f;
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
      end
   end

   // Bus events decoded from the filtered lines.
   // Start and stop need the clock high in two successive filtered samples, so a data
   // edge that races a clock edge is read as a data bit, never as a frame boundary.
   // The one-sample delay of scl_q is the price of that, and it is far below a bit time.
   logic scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = scl_f & ~scl_q;
   assign scl_fall = ~scl_f & scl_q;
   assign start_c = scl_f & scl_q & sda_q & ~sda_f;
   assign stop_c = scl_f & scl_q & ~sda_q & sda_f;

   // ----------------------------------------
   // Bus state machine and registers
   // ----------------------------------------
   // Registers are held here; the bit counter counts received or sent bits.
   iox_state_type st, next_st;
   logic [7:0] shreg, next_shreg;
   logic [2:0] bitcnt, next_bitcnt;
   logic rd, next_rd, ptr_ok, next_ptr_ok, drive, next_drive;
   // Set by the first clock rise of a byte; without it the zero count left by a start
   // could not be told apart from the zero count that follows eight bits.
   logic got_bit, next_got_bit;
   logic [1:0] ptr, next_ptr;
   logic [7:0] outr, pol, cfg, inr, next_outr, next_pol, next_cfg, next_inr;
   logic [7:0] live;

   // Live pin view, inverted where a polarity bit is set; the input register is a capture of it.
   assign live = p2 ^ pol;

   // Read multiplexer, used both when a read starts and when the master acknowledges a
   // byte and asks for the next one. The pointer is only two bits wide, so every code
   // selects a register and no default is needed.
   function automatic logic [7:0] reg_read(input logic [1:0] p, input logic [7:0] in_v,
                                           input logic [7:0] o, input logic [7:0] pl,
                                           input logic [7:0] c);
      unique case (p)
         PTR_INPUT: reg_read = in_v;
         PTR_OUTPUT: reg_read = o;
         PTR_POLARITY: reg_read = pl;
         PTR_CONFIG: reg_read = c;
      endcase
   endfunction

   always_comb begin
      next_st = st;
      next_shreg = shreg;
      next_bitcnt = bitcnt;
      next_rd = rd;
      next_ptr_ok = ptr_ok;
      next_drive = drive;
      next_got_bit = got_bit;
      next_ptr = ptr;
      next_outr = outr;
      next_pol = pol;
      next_cfg = cfg;
      next_inr = inr;
      // Input register follows the pins except while a read is shifting it out,
      // so a byte on the wire never tears; the interrupt shows the difference.
      if (!(st == ST_RBYTE && ptr == PTR_INPUT)) next_inr = live;
      if (start_c) begin
         // A start, repeated or not, always wins over whatever byte was in flight.
         // That lets a master abandon a frame without a stop and begin a fresh one.
         next_st = ST_ADDR;
         next_bitcnt = 3'h0;
         next_got_bit = 1'b0;
         next_drive = 1'b0;
      end else if (stop_c) begin
         next_st = ST_IDLE;
         next_drive = 1'b0;
      end else begin
         unique case (st)
            ST_IDLE: next_drive = 1'b0;
            ST_ADDR, ST_WBYTE: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_f};
                  next_bitcnt = bitcnt + 3'h1;
                  next_got_bit = 1'b1;
               end
               // The counter wraps to zero after eight bits, but it is also zero on the
               // clock fall that closes a start; got_bit tells the two apart, so a stale
               // shift register is never matched as an address.
               if (scl_fall && got_bit && bitcnt == 3'h0 && st == ST_ADDR) begin
                  // Full byte seen: match address and take direction bit.
                  if (shreg[7:2] == ADDR_UPPER && shreg[1] == a2) begin
                     next_rd = shreg[0];
                     next_drive = 1'b1;
                     next_ptr_ok = 1'b0;
                     next_st = ST_ACK;
                  end else begin
                     next_st = ST_SKIP;
                  end
               end else if (scl_fall && got_bit && bitcnt == 3'h0 && st == ST_WBYTE) begin
                  next_drive = 1'b1;
                  next_st = ST_ACK;
                  if (!ptr_ok) begin
                     next_ptr = shreg[1:0];
                     next_ptr_ok = 1'b1;
                  end else begin
                     unique case (ptr)
                        PTR_INPUT: ;
                        PTR_OUTPUT: next_outr = shreg;
                        PTR_POLARITY: next_pol = shreg;
                        PTR_CONFIG: next_cfg = shreg;
                     endcase
                  end
               end
            end
            ST_ACK: if (scl_fall) begin
               next_bitcnt = 3'h0;
               next_got_bit = 1'b0;
               if (rd) begin
                  next_st = ST_RBYTE;
                  next_shreg = reg_read(ptr, inr, outr, pol, cfg);
                  next_drive = ~next_shreg[7];
               end else begin
                  next_st = ST_WBYTE;
                  next_drive = 1'b0;
               end
            end
            ST_RBYTE: begin
               if (scl_fall) begin
                  next_bitcnt = bitcnt + 3'h1;
                  next_shreg = {shreg[6:0], 1'b0};
                  next_drive = ~shreg[6];
                  if (bitcnt == 3'h7) begin
                     next_st = ST_RACK;
                     next_drive = 1'b0;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise && sda_f) next_st = ST_SKIP; // Master NACK ends the read.
               else if (scl_fall) begin
                  // Master acknowledged: the next byte of the same register starts on
                  // this very fall, so its first bit is loaded now and not one bit late.
                  next_st = ST_RBYTE;
                  next_bitcnt = 3'h0;
                  next_shreg = reg_read(ptr, inr, outr, pol, cfg);
                  next_drive = ~next_shreg[7];
               end
            end
            ST_SKIP: next_drive = 1'b0;
            // The state needs three bits for seven states; the spare code can only come
            // from an upset, and it recovers to idle with the data line released.
            default: begin
               next_st = ST_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_IDLE;
         shreg <= 8'h00;
         bitcnt <= 3'h0;
         rd <= 1'b0;
         ptr_ok <= 1'b0;
         drive <= 1'b0;
         got_bit <= 1'b0;
         ptr <= PTR_INPUT;
         outr <= RST_OUTPUT;
         pol <= RST_POLARITY;
         cfg <= RST_CONFIG;
         inr <= 8'h00;
      end else if (clk_en) begin
         st <= next_st;
         shreg <= next_shreg;
         bitcnt <= next_bitcnt;
         rd <= next_rd;
         ptr_ok <= next_ptr_ok;
         drive <= next_drive;
         got_bit <= next_got_bit;
         ptr <= next_ptr;
         outr <= next_outr;
         pol <= next_pol;
         cfg <= next_cfg;
         inr <= next_inr;
      end
   end

   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // A config bit of one means input, so the pin enable is its complement.
   // Both the output value and the enable come straight from registers, so a pin never
   // glitches while the bus machine is busy; a new value appears on the clock on which the slave
   // starts to drive the acknowledge of the data byte that carried it.
   assign port_out = outr;
   assign port_oe = ~cfg;
   assign sda_out = 1'b0;
   assign sda_oe = drive;
   // Interrupt follows the mismatch between live pins and the captured register.
   // Outside a read of the input register the capture follows one clock behind, so the
   // flag is a short pulse; a host that needs a level must poll the input register.
   // The pin is open drain: the enable pulls it low, and release leaves it to the pull-up.
   assign int_n_out = 1'b0;
   assign int_n_oe = (live != inr);
   assign int_out_reg = outr;
   assign int_cfg_reg = cfg;
endmodule
`default_nettype wire

// *** tb/iox_checker.sv ***
`default_nettype none
module iox_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe,
   input wire logic [7:0] port_in,
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe,
   input wire logic int_n_out,
   input wire logic int_n_oe,
   input wire logic [7:0] int_out_reg,
   input wire logic [7:0] int_cfg_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] idle_cnt;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Counts quiet bus cycles with steady pins, so a stale interrupt can be caught.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt <= 6'h00;
      end else if (scl_in && sda_in && $stable(port_in)) begin
         idle_cnt <= (idle_cnt == 6'h28) ? idle_cnt : idle_cnt + 6'h01;
      end else begin
         idle_cnt <= 6'h00;
      end
   end
   // A quiet bus with no pending interrupt.
   sequence s_quiet;
      !int_n_oe && scl_in && sda_in;
   endsequence
   sequence s_no_ack;
      !sda_oe [*4];
   endsequence
   property p_rst_state;
      $rose(rst_n) |-> port_oe == 8'h00 && port_out == 8'hff && int_cfg_reg == 8'hff;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
   property p_rst_bus;
      $rose(rst_n) |-> s_no_ack;
   endproperty
   a_rst_bus: assert property (p_rst_bus) else $error("bus active after reset");
   property p_dir;
      $stable(int_cfg_reg) [*3] |-> port_oe == ~int_cfg_reg;
   endproperty
   a_dir: assert property (p_dir) else $error("pin enables differ from config");
   property p_out;
      $stable(int_out_reg) [*3] |-> port_out == int_out_reg;
   endproperty
   a_out: assert property (p_out) else $error("pins differ from output register");
   property p_int_od;
      int_n_oe |-> !int_n_out;
   endproperty
   a_int_od: assert property (p_int_od) else $error("interrupt not pulled low");
   property p_sda_edge;
      $changed(sda_oe) |-> !scl_in;
   endproperty
   a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
   property p_int_rise;
      s_quiet ##0 ((port_in ^ $past(port_in)) != 8'h00) |-> ##[1:6] int_n_oe;
   endproperty
   a_int_rise: assert property (p_int_rise) else $error("no interrupt on pin change");
   property p_int_clear;
      idle_cnt == 6'h28 |-> !int_n_oe;
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("interrupt stuck");
endmodule
`default_nettype wire

// *** tb/iox_i2c_master.sv ***
`default_nettype none
module iox_i2c_master (
   input wire logic clk_sys,
   input wire logic sda_line,
   output logic scl,
   output logic sda_rel
);
   timeunit 1ns;
   timeprecision 1ns;
   // The clock stands high between frames; a quarter bit of 13 cycles keeps it under 400 kHz.
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic q();
      repeat (13) @(posedge clk_sys);
   endtask
   // Also serves as repeated start, since data is released first.
   task automatic start();
      sda_rel <= 1'b1;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b0;
      q();
      scl <= 1'b0;
      q();
   endtask
   task automatic stop();
      sda_rel <= 1'b0;
      q();
      scl <= 1'b1;
      q();
      sda_rel <= 1'b1;
      q();
   endtask
   // Eight bits most significant first, then the acknowledge bit.
   task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] r, output logic k);
      for (int i = 8; i >= 0; i--) begin
         sda_rel <= (i == 0) ? ak : d[i - 1];
         q();
         scl <= 1'b1;
         q();
         if (i == 0) k = sda_line;
         else r[i - 1] = sda_line;
         q();
         scl <= 1'b0;
         q();
      end
   endtask
endmodule
`default_nettype wire

// *** tb/iox_core_tb.sv ***
`default_nettype none
module iox_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import iox_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic addr_sel = 1'b0;
   logic [7:0] port_in = 8'h00;
   logic scl, sda_rel, sda_line, sda_out, sda_oe, int_n_out, int_n_oe, ack;
   logic [7:0] port_out, port_oe, out_r, cfg_r, rd;
   int n_errors = 0;
   int check_count = 0;
   // Pull-up: the data line is low only while some party pulls it.
   assign sda_line = sda_rel & ~sda_oe;
   always #25 clk_sys = ~clk_sys;
   iox_core u_dut (.clk_sys, .rst_n, .clk_en(1'b1), .scl_in(scl), .sda_in(sda_line), .sda_out,
      .sda_oe, .addr_sel, .port_in, .port_out, .port_oe, .int_n_out, .int_n_oe,
      .int_out_reg(out_r), .int_cfg_reg(cfg_r));
   iox_i2c_master u_mst (.clk_sys, .sda_line, .scl, .sda_rel);
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask
   // Address byte: fixed upper bits, select level, direction; then pointer and data.
   task automatic wr(input logic a, input logic [1:0] p, input logic [7:0] d, output logic k);
      logic [7:0] r;
      logic k2;
      u_mst.start();
      u_mst.xfer({ADDR_UPPER, a, 1'b0}, 1'b1, r, k);
      u_mst.xfer({6'h00, p}, 1'b1, r, k2);
      u_mst.xfer(d, 1'b1, r, k2);
      u_mst.stop();
   endtask
   task automatic reg_chk(input string name, input logic [1:0] p, input logic [7:0] exp);
      logic [7:0] r;
      logic k;
      u_mst.start();
      u_mst.xfer({ADDR_UPPER, addr_sel, 1'b0}, 1'b1, r, k);
      u_mst.xfer({6'h00, p}, 1'b1, r, k);
      u_mst.start();
      u_mst.xfer({ADDR_UPPER, addr_sel, 1'b1}, 1'b1, r, k);
      u_mst.xfer(8'hff, 1'b1, rd, k);
      u_mst.stop();
      check(name, exp, rd);
   endtask
   // Bounded wait on the interrupt; running out shows up as a mismatch.
   task automatic int_wait(input logic lvl);
      for (int i = 0; i < 20 && int_n_oe !== lvl; i++) @(negedge clk_sys);
      check("interrupt", {7'h00, lvl}, {7'h00, int_n_oe});
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      check("dir", 8'h00, port_oe);
      check("sda_out", 8'h00, {7'h00, sda_out});
      check("int_n_out", 8'h00, {7'h00, int_n_out});
      reg_chk("pol", PTR_POLARITY, RST_POLARITY);
      reg_chk("cfg", PTR_CONFIG, RST_CONFIG);
      $display("test reset done");
      wr(1'b0, PTR_CONFIG, 8'h0f, ack);
      wr(1'b0, PTR_OUTPUT, 8'ha5, ack);
      check("dir", 8'hf0, port_oe);
      check("out", 8'ha5, port_out);
      check("out_reg", 8'ha5, out_r);
      check("cfg_reg", 8'h0f, cfg_r);
      reg_chk("out_rd", PTR_OUTPUT, 8'ha5);
      port_in <= 8'h3c;
      wr(1'b0, PTR_POLARITY, 8'h0f, ack);
      reg_chk("in", PTR_INPUT, 8'h33);
      $display("test ports done");
      for (int s = 0; s < 2; s++) begin
         addr_sel <= s[0];
         @(posedge clk_sys);
         wr(s[0], PTR_OUTPUT, {7'h00, s[0]}, ack);
         check("ack", 8'h00, {7'h00, ack});
         wr(~s[0], PTR_OUTPUT, 8'h5a, ack);
         check("nack", 8'h01, {7'h00, ack});
         check("out", {7'h00, s[0]}, port_out);
      end
      $display("test address done");
      port_in <= 8'h3d;
      int_wait(1'b1);
      int_wait(1'b0);
      $display("test interrupt done");
      rst_n <= 1'b0;
      repeat (2) @(negedge clk_sys);
      check("dir", 8'h00, port_oe);
      check("cfg", RST_CONFIG, cfg_r);
      check("out", RST_OUTPUT, port_out);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (10) @(posedge clk_sys);
      $display("test pin reset done");
      final_report();
   end
endmodule
bind iox_core iox_checker u_chk (.clk_sys, .rst_n, .scl_in, .sda_in, .sda_oe, .port_in,
   .port_out, .port_oe, .int_n_out, .int_n_oe, .int_out_reg, .int_cfg_reg);
`default_nettype wire
